// ==== hw/bapp_defines.vh ====
`ifndef BAPP_DEFINES_VH
`define BAPP_DEFINES_VH
// Master address phase states
`define BAPP_ST_IDLE   2'h0
`define BAPP_ST_MEM    2'h1
`define BAPP_ST_DS0    2'h2
`define BAPP_ST_DS1    2'h3
// Snoop error pipeline: error asserts this many cycles after the start strobe
`define BAPP_APE_DELAY 2
// Burst addresses are double-word aligned: low address bits cleared
`define BAPP_DW_MASK   32'hfffffff8
// Receiver tag field position inside a direct-store reply first beat
`define BAPP_RTAG_LSB  0
`define BAPP_TAG_W     4
`endif

// ==== hw/bapp_core.v ====
// Function
// - Burst address is aligned critical or first double
// - Burst address held, never incremented
// - Address driven the cycle after qualified grant
// - Memory address released cycle after acknowledge
// - Snoop address sampled only in start cycle
// - Direct-store tenure: tag packet, then address packet
// - Direct-store beats follow grant, then next cycle
// - Direct-store reply carries control, status and tag
// - Direct-store address released cycle after acknowledge
// - Snoop only direct-store first beat, matching tag
// - Four odd parity bits, one per byte
// - Even parity gives checkstop or machine check
// - Variant: enabled checking always forces checkstop
// - Error only for recognized snooped transaction types
// - Variant: no error when checking disabled
// - Error asserts second cycle, released third
// - Transfer start held exactly one cycle
// - Transfer start negated during direct-store tenure
`timescale 1ns/1ns
`default_nettype none
`include "bapp_defines.vh"

module bapp_core #(
  parameter VARIANT_FORCE_CHECKSTOP = 0,  // Enabled checking always checkstops
  parameter VARIANT_APE_NEEDS_CHECK = 0   // Error pin silent when checking off
) (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  // Master request side
  input  wire        req_i,                   // Start tenure, level
  input  wire        req_ds_i,                // Direct-store tenure
  input  wire        req_burst_i,             // Burst memory transfer
  input  wire [31:0] req_addr_i,              // Physical address
  input  wire [31:0] req_ds_ctl_i,            // Packet 0 control/tag or reply word
  output wire        req_ready_o,             // Request taken this cycle
  output reg         busy_o,                  // Tenure in progress
  input  wire        qual_grant_i,            // Qualified bus grant
  // Address bus pins
  output reg  [31:0] addr_o,
  output reg         addr_oe_o,
  input  wire [31:0] addr_i,
  output wire [3:0]  address_parity_o,
  input  wire [3:0]  address_parity_i,
  output reg         transfer_start_n_o,
  output reg         ext_transfer_start_n_o,
  output reg         addr_bus_busy_n_o,
  input  wire        transfer_start_n_i,
  input  wire        ext_transfer_start_n_i,
  input  wire        addr_acknowledge_n_i,
  output wire        addr_parity_error_n_o,
  output reg         addr_parity_error_n_oe_o,
  // Configuration and exception reporting
  input  wire        machine_check_enable_i,
  input  wire        parity_check_en_i,       // From hw_config_reg
  input  wire        snoop_mem_recog_i,       // Memory snoop type recognized
  input  wire [3:0]  processor_tag_i,
  output reg         checkstop_o,             // Pulse
  output reg         machine_check_o,         // Pulse
  output reg  [31:0] snoop_addr_o,            // Last sampled snoop address
  output reg         snoop_valid_o            // Pulse, snoop_addr_o fresh
);

  // ************************************************************
  // Input synchronisers for bus pins
  // ************************************************************
  reg [2:0] ts_sync;      // Transfer start stages
  reg [2:0] xts_sync;     // Extended start stages
  reg [2:0] addr_acknowledge_n_sync;    // Acknowledge stages
  reg [2:0] gnt_sync;     // Grant stages
  reg [31:0] a_s1;        // Address stage 1
  reg [31:0] a_s2;        // Address stage 2
  reg [31:0] a_s3;        // Address stage 3
  reg [3:0]  p_s1;        // Parity stage 1
  reg [3:0]  p_s2;        // Parity stage 2
  reg [3:0]  p_s3;        // Parity stage 3

  // Three stage pipe; stage 1 feeds only stage 2
  // Address and parity ride the same pipe as the strobes
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ts_sync   <= 3'h7;
      xts_sync  <= 3'h7;
      addr_acknowledge_n_sync <= 3'h7;
      gnt_sync  <= 3'h0;
      a_s1      <= 32'h0;
      a_s2      <= 32'h0;
      a_s3      <= 32'h0;
      p_s1      <= 4'h0;
      p_s2      <= 4'h0;
      p_s3      <= 4'h0;
    end else if (clk_en_i) begin
      ts_sync   <= {ts_sync[1:0], transfer_start_n_i};
      xts_sync  <= {xts_sync[1:0], ext_transfer_start_n_i};
      addr_acknowledge_n_sync <= {addr_acknowledge_n_sync[1:0], addr_acknowledge_n_i};
      gnt_sync  <= {gnt_sync[1:0], qual_grant_i};
      a_s1      <= addr_i;
      a_s2      <= a_s1;
      a_s3      <= a_s2;
      p_s1      <= address_parity_i;
      p_s2      <= p_s1;
      p_s3      <= p_s2;
    end
  end

  // Grant is a level: it counts once stages two and three agree
  wire gnt_seen  = gnt_sync[1] & gnt_sync[2];
  // Strobes and acknowledge last one bus cycle, so two stages never agree
  // on them; stage three alone marks the pulse, which also keeps it in
  // step with the address and parity held in a_s3 and p_s3
  wire ts_seen   = ~ts_sync[2];
  wire xts_seen  = ~xts_sync[2];
  wire addr_acknowledge_n_seen = ~addr_acknowledge_n_sync[2];
  // Rising edge of each start, one pulse per strobe
  reg  ts_prev;
  reg  xts_prev;
  wire ts_evt  = ts_seen & ~ts_prev;
  wire xts_evt = xts_seen & ~xts_prev;

  // ************************************************************
  // Master address tenure
  // ************************************************************
  reg [1:0]  state;       // Tenure state
  reg [1:0]  next_state;  // Next tenure state
  reg        ds;          // Captured direct-store flag
  reg [31:0] cap_addr;    // Captured address packet
  reg [31:0] cap_ctl;     // Captured control/tag packet

  // Accept a request only when idle; one tenure at a time
  assign req_ready_o = (state == `BAPP_ST_IDLE) && !busy_o && req_i;

  // Odd parity per byte, bit 0 covers lines 0 to 7 (msb byte)
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_par
      assign address_parity_o[g] = ~(^addr_o[31-8*g -: 8]);
    end
  endgenerate

  // Next state selection
  always @* begin
    next_state = state;
    case (state)
      `BAPP_ST_IDLE: begin
        if (busy_o && gnt_seen)
          next_state = ds ? `BAPP_ST_DS0 : `BAPP_ST_MEM;
      end
      `BAPP_ST_MEM: begin
        if (addr_acknowledge_n_seen)
          next_state = `BAPP_ST_IDLE;
      end
      `BAPP_ST_DS0: begin
        next_state = `BAPP_ST_DS1;
      end
      `BAPP_ST_DS1: begin
        if (addr_acknowledge_n_seen)
          next_state = `BAPP_ST_IDLE;
      end
      default: next_state = `BAPP_ST_IDLE;
    endcase
  end

  // Tenure registers and pin drive
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state                  <= `BAPP_ST_IDLE;
      busy_o                 <= 1'b0;
      ds                     <= 1'b0;
      cap_addr               <= 32'h0;
      cap_ctl                <= 32'h0;
      addr_o                 <= 32'h0;
      addr_oe_o              <= 1'b0;
      transfer_start_n_o     <= 1'b1;
      ext_transfer_start_n_o <= 1'b1;
      addr_bus_busy_n_o      <= 1'b1;
    end else if (clk_en_i) begin
      state                  <= next_state;
      // Strobes last one cycle by default
      transfer_start_n_o     <= 1'b1;
      ext_transfer_start_n_o <= 1'b1;
      if (req_ready_o) begin
        busy_o   <= 1'b1;
        ds       <= req_ds_i;
        cap_addr <= req_burst_i ? (req_addr_i & `BAPP_DW_MASK) : req_addr_i;
        cap_ctl  <= req_ds_ctl_i;
      end
      case (state)
        `BAPP_ST_IDLE: begin
          if (busy_o && gnt_seen) begin
            addr_oe_o         <= 1'b1;
            addr_bus_busy_n_o <= 1'b0;
            if (ds) begin
              addr_o                 <= cap_ctl;
              ext_transfer_start_n_o <= 1'b0;
            end else begin
              addr_o             <= cap_addr;
              transfer_start_n_o <= 1'b0;
            end
          end
        end
        `BAPP_ST_DS0: begin
          addr_o <= cap_addr;
        end
        default: begin
          if (addr_acknowledge_n_seen) begin
            addr_oe_o         <= 1'b0;
            addr_bus_busy_n_o <= 1'b1;
            busy_o            <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Snooper and parity checker
  // ************************************************************
  reg [`BAPP_APE_DELAY-1:0] err_pipe;  // Error delay line
  reg [3:0] snoop_par;                 // Parity latched at strobe
  reg       mine;                      // Own tenure on the bus
  wire [3:0] bad_byte;                 // Even parity per byte

  // Byte plus its parity bit must hold an odd count of ones
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chk
      assign bad_byte[g] = ~(^{a_s3[31-8*g -: 8], p_s3[g]});
    end
  endgenerate

  // Direct-store snoop only on matching reply tag
  wire tag_hit = a_s3[`BAPP_RTAG_LSB +: `BAPP_TAG_W] == processor_tag_i;
  wire recog   = (ts_evt & snoop_mem_recog_i) | (xts_evt & tag_hit);
  // Any bad byte flags the whole address
  wire par_bad = |bad_byte;
  // Variant silences error when checking off
  wire ape_ok  = (VARIANT_APE_NEEDS_CHECK == 0) | parity_check_en_i;
  // Own tenures are never checked; checking must be enabled
  wire err_now = recog & par_bad & parity_check_en_i & ~mine & ape_ok;

  // Snoop sampling, error timing and exception selection
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ts_prev                  <= 1'b0;
      xts_prev                 <= 1'b0;
      mine                     <= 1'b0;
      snoop_par                <= 4'h0;
      err_pipe                 <= {`BAPP_APE_DELAY{1'b0}};
      addr_parity_error_n_oe_o <= 1'b0;
      checkstop_o              <= 1'b0;
      machine_check_o          <= 1'b0;
      snoop_addr_o             <= 32'h0;
      snoop_valid_o            <= 1'b0;
    end else if (clk_en_i) begin
      // Edge history for the start strobes
      ts_prev         <= ts_seen;
      xts_prev        <= xts_seen;
      // Own drive, late enough to cover its own synchronised strobe
      mine            <= addr_oe_o;
      // Report pulses last one cycle
      snoop_valid_o   <= 1'b0;
      checkstop_o     <= 1'b0;
      machine_check_o <= 1'b0;
      if ((ts_evt | xts_evt) && !mine) begin
        snoop_addr_o  <= a_s3;
        snoop_par     <= p_s3;
        snoop_valid_o <= recog;
      end
      err_pipe                 <= {err_pipe[`BAPP_APE_DELAY-2:0], err_now};
      addr_parity_error_n_oe_o <= err_pipe[`BAPP_APE_DELAY-2];
      if (err_now) begin
        if (VARIANT_FORCE_CHECKSTOP != 0 || !machine_check_enable_i)
          checkstop_o <= 1'b1;
        else
          machine_check_o <= 1'b1;
      end
    end
  end

  assign addr_parity_error_n_o = 1'b0;

endmodule // bapp_core
`default_nettype wire

// ==== tb/bapp_core_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module bapp_core_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] addr_o,
  input wire logic        addr_oe_o,
  input wire logic [3:0]  address_parity_o,
  input wire logic        transfer_start_n_o,
  input wire logic        ext_transfer_start_n_o,
  input wire logic        addr_bus_busy_n_o,
  input wire logic        transfer_start_n_i,
  input wire logic        ext_transfer_start_n_i,
  input wire logic        addr_acknowledge_n_i,
  input wire logic        addr_parity_error_n_o,
  input wire logic        addr_parity_error_n_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Packet 1 follows packet 0 with both strobes negated
  sequence ds_beats;
    addr_oe_o ##1 (addr_oe_o && ext_transfer_start_n_o && transfer_start_n_o);
  endsequence
  // Address held through the acknowledge sync, then released
  sequence held_then_free;
    addr_oe_o[*3] ##[1:3] !addr_oe_o;
  endsequence
  ts_pulse_a: assert property ($fell(transfer_start_n_o) |=> transfer_start_n_o)
    else $error("start strobe too long");
  ts_abb_a: assert property (!transfer_start_n_o |-> !addr_bus_busy_n_o && $rose(addr_oe_o))
    else $error("address not driven with start");
  par_out_a: assert property (addr_oe_o |-> address_parity_o ==
    {~^addr_o[7:0], ~^addr_o[15:8], ~^addr_o[23:16], ~^addr_o[31:24]}) else $error("bad parity");
  ds_two_a: assert property (!ext_transfer_start_n_o |-> transfer_start_n_o ##0 ds_beats)
    else $error("direct-store beats wrong");
  addr_held_a: assert property (addr_oe_o && $past(addr_oe_o) && $past(ext_transfer_start_n_o)
    |-> $stable(addr_o)) else $error("address moved");
  ack_rel_a: assert property (addr_oe_o && $fell(addr_acknowledge_n_i) |-> held_then_free)
    else $error("release after acknowledge wrong");
  ape_low_a: assert property (addr_parity_error_n_oe_o |-> !addr_parity_error_n_o
    ##1 !addr_parity_error_n_oe_o) else $error("error line misdriven");
  ape_time_a: assert property ($rose(addr_parity_error_n_oe_o) |->
    $past(!transfer_start_n_i || !ext_transfer_start_n_i, 5) ||
    $past(!transfer_start_n_i || !ext_transfer_start_n_i, 6)) else $error("error late or early");
endmodule  // bapp_core_chk
`default_nettype wire

// ==== tb/bapp_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
// Other master and target on the far side of the address bus
module bapp_far_end (
  input  wire logic   core_clk_i,
  input  wire logic   ts_n_i,
  input  wire logic   xts_n_i,
  output logic        ack_n_o = 1'b1,
  output logic [31:0] addr_o = 32'h0,
  output logic [3:0]  par_o = 4'h0,
  output logic        ts_n_o = 1'b1,
  output logic        xts_n_o = 1'b1
);
  int ack_wait = 1;  // Acknowledge delay, raised for a slow target
  // one-cycle strobe with address, then strobe negated and address and parity inverted
  task automatic snoop(input logic ds, input logic [31:0] a, input logic [3:0] p);
    @(posedge core_clk_i);
    ts_n_o <= ds;
    xts_n_o <= !ds;
    addr_o <= a;
    par_o <= p;
    @(posedge core_clk_i);
    ts_n_o <= 1'b1;
    xts_n_o <= 1'b1;
    addr_o <= ~a;
    par_o <= ~p;
  endtask
  // Acknowledge each tenure of the block ack_wait + 1 cycles after its strobe is seen
  always @(posedge core_clk_i) begin
    if (!ts_n_i || !xts_n_i) begin
      repeat (ack_wait + 1) @(posedge core_clk_i);
      ack_n_o <= 1'b0;
      @(posedge core_clk_i);
      ack_n_o <= 1'b1;
    end
  end
endmodule  // bapp_far_end
`default_nettype wire

// ==== tb/bapp_core_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module bapp_core_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0, req_ds = 1'b0, burst = 1'b0, me = 1'b0, pce = 1'b1, recog = 1'b1;
  logic gnt = 1'b0;
  logic [31:0] req_addr = 32'h0, ds_ctl = 32'h0, addr, p_addr, s_addr;
  logic [3:0] par, p_par;
  logic ready, busy, oe, ts, xts, abb, addr_parity_error_n, ape_oe, cs, mc, ack, p_ts, p_xts;
  int miscompares = 0, checks_done = 0, n_ape = 0, n_cs = 0, n_mc = 0;
  always #5 core_clk_i = ~core_clk_i;
  bapp_core bapp_core_inst (.core_clk_i, .rst_n_i, .clk_en_i(1'b1), .req_i, .req_ds_i(req_ds),
    .req_burst_i(burst), .req_addr_i(req_addr), .req_ds_ctl_i(ds_ctl), .req_ready_o(ready),
    .busy_o(busy), .qual_grant_i(gnt), .addr_o(addr), .addr_oe_o(oe),
    .addr_i(oe ? addr : p_addr), .address_parity_o(par), .address_parity_i(oe ? par : p_par),
    .transfer_start_n_o(ts), .ext_transfer_start_n_o(xts), .addr_bus_busy_n_o(abb),
    .transfer_start_n_i(ts & p_ts), .ext_transfer_start_n_i(xts & p_xts),
    .addr_acknowledge_n_i(ack), .addr_parity_error_n_o(addr_parity_error_n), .addr_parity_error_n_oe_o(ape_oe),
    .machine_check_enable_i(me), .parity_check_en_i(pce), .snoop_mem_recog_i(recog),
    .processor_tag_i(4'h5), .checkstop_o(cs), .machine_check_o(mc), .snoop_addr_o(s_addr),
    .snoop_valid_o());
  bapp_far_end bapp_far_end_inst (.core_clk_i, .ts_n_i(ts), .xts_n_i(xts), .ack_n_o(ack),
    .addr_o(p_addr), .par_o(p_par), .ts_n_o(p_ts), .xts_n_o(p_xts));
  // Count error pulls and exception pulses
  always @(posedge core_clk_i) begin
    n_ape <= n_ape + int'(ape_oe);
    n_cs <= n_cs + int'(cs);
    n_mc <= n_mc + int'(mc);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One tenure of the block, judged beat by beat
  task automatic tenure(input logic ds, bst, input logic [31:0] a, c, input int w);
    int n;
    bapp_far_end_inst.ack_wait = w;
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_ds <= ds;
    burst <= bst;
    req_addr <= a;
    ds_ctl <= c;
    #1;
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(posedge core_clk_i) #1;
    @(posedge core_clk_i);
    req_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk({31'h0, oe}, 32'h0);
    @(posedge core_clk_i);
    gnt <= 1'b1;
    #1;
    for (n = 0; n < 20 && (ds ? xts : ts) !== 1'b0; n++) @(posedge core_clk_i) #1;
    chk(n, 4);
    chk(addr, ds ? c : (bst ? a & ~32'h7 : a));
    @(posedge core_clk_i);
    gnt <= 1'b0;
    #1;
    if (ds) begin
      chk(addr, a);
    end else begin
      chk(addr, bst ? a & ~32'h7 : a);
    end
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge core_clk_i) #1;
    chk({31'h0, oe}, 32'h0);
  endtask
  // One snooped start with good or bad parity
  task automatic snoop_case(input logic ds, input logic [31:0] a, input logic bad, input int e);
    int a0 = n_ape, s0 = n_cs, m0 = n_mc;
    bapp_far_end_inst.snoop(ds, a, {~^a[7:0], ~^a[15:8], ~^a[23:16], ~^a[31:24] ^ bad});
    repeat (8) @(posedge core_clk_i);
    #1;
    chk(n_ape - a0, e);
    chk(n_mc - m0, me ? e : 0);
    chk(n_cs - s0, me ? 0 : e);
    chk(s_addr, a);
  endtask
  task automatic cfg(input logic r, m, p);
    @(posedge core_clk_i);
    recog <= r;
    me <= m;
    pce <= p;
  endtask
  task automatic t_memory();
    tenure(1'b0, 1'b0, 32'h1234_5677, 32'h0, 1);
    tenure(1'b0, 1'b1, 32'h8000_001d, 32'h0, 6);
  endtask
  task automatic t_direct_store();
    tenure(1'b1, 1'b0, 32'hc0de_0ff0, 32'h0000_0a53, 2);
  endtask
  // Parity faults by tenure type, tag and configuration
  task automatic t_snoop();
    snoop_case(1'b1, 32'h0000_1235, 1'b1, 1);
    snoop_case(1'b1, 32'h0000_1236, 1'b1, 0);
    snoop_case(1'b1, 32'h0000_1235, 1'b0, 0);
    snoop_case(1'b0, 32'hffff_0000, 1'b1, 1);
    cfg(1'b0, 1'b0, 1'b1);
    snoop_case(1'b0, 32'hffff_0000, 1'b1, 0);
    cfg(1'b1, 1'b1, 1'b1);
    snoop_case(1'b1, 32'h0000_1235, 1'b1, 1);
    cfg(1'b1, 1'b1, 1'b0);
    snoop_case(1'b1, 32'h0000_1235, 1'b1, 0);
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_memory();
    t_direct_store();
    t_snoop();
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge core_clk_i);
    miscompares++;
    summarize();
  end
endmodule  // bapp_core_tb_top
bind bapp_core bapp_core_chk bapp_core_chk_inst (.core_clk_i, .rst_n_i, .addr_o, .addr_oe_o,
  .address_parity_o, .transfer_start_n_o, .ext_transfer_start_n_o, .addr_bus_busy_n_o,
  .transfer_start_n_i, .ext_transfer_start_n_i, .addr_acknowledge_n_i,
  .addr_parity_error_n_o, .addr_parity_error_n_oe_o);
`default_nettype wire
